// File: cdap_pkg.sv
// shared constants for the cpu debug access over aux port block
package cdap_pkg;

	// ----------------------------------------
	// message type codes
	// ----------------------------------------
	localparam logic [5:0] MTC_DEBUG_STATUS = 6'h00;
	localparam logic [5:0] MTC_SDI_DATA     = 6'h38;
	localparam logic [5:0] MTC_SDO_DATA     = 6'h39;
	localparam logic [5:0] MTC_ERROR        = 6'h08;

	// ----------------------------------------
	// message fields
	// ----------------------------------------
	localparam int         WORD_W           = 35;
	localparam int         CNT_W            = 6;
	localparam logic [7:0] ERR_INVALID_TYPE = 8'h01;
	localparam logic       STATUS_ENTERED   = 1'b1;
	localparam logic       STATUS_EXITED    = 1'b0;

	// ----------------------------------------
	// link selection
	// ----------------------------------------
	localparam logic PATH_DEDICATED = 1'b0;
	localparam logic PATH_AUX       = 1'b1;

endpackage : cdap_pkg

// File: cdap_debug_access.sv
// aux port routing of cpu serial debug traffic
`timescale 1ns/1ps

// Notes on behaviour
// - cpu debug reached by aux port or dedicated pins, one path at a time
// - debug serial data travels only inside vendor messages once aux path owns it
// - with aux path selected, port can enable and force cpu debug mode
// - on debug entry send status message with status field one
// - cpu serial output returned in serial-data-out messages
// - on debug exit send status message with status field zero
// - synchronous self-clocked serial mode toward system interface unit
// - internal serial transfer runs at system clock rate
// - unknown message type code answered with invalid type error message
module cdap_debug_access
	import cdap_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              arst_n_in,
	input  wire logic              aux_port_reset_n_in,
	input  wire logic              dev_ctrl_wr_in,
	input  wire logic              dev_ctrl_aux_sel_in,
	input  wire logic              msg_in_valid_in,
	input  wire logic [5:0]        msg_in_type_in,
	input  wire logic [WORD_W-1:0] msg_in_data_in,
	output logic                   msg_in_ready_out,
	output logic                   msg_out_valid_out,
	output logic [5:0]             msg_out_type_out,
	output logic [WORD_W-1:0]      msg_out_data_out,
	input  wire logic              msg_out_ready_in,
	input  wire logic              cpu_in_debug_in,
	output logic                   cpu_debug_enable_out,
	output logic                   cpu_debug_force_out,
	input  wire logic              ded_serial_debug_data_in,
	output logic                   ded_serial_debug_data_out,
	output logic                   serial_debug_data_out,
	input  wire logic              serial_debug_data_in,
	output logic                   serial_debug_clk_en_out,
	output logic                   aux_path_out
);

	typedef enum logic [1:0] {CDAP_IDLE, CDAP_SHIFT, CDAP_ANSWER} cdap_state_t;

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [1:0] dbg_sync_q;
	logic [1:0] prst_sync_q;
	logic [1:0] ded_sync_q;
	logic       dbg_prev_q;

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			dbg_sync_q  <= 2'h0;
			prst_sync_q <= 2'h0;
			ded_sync_q  <= 2'h0;
			dbg_prev_q  <= 1'b0;
		end
		else
		begin
			dbg_sync_q  <= {dbg_sync_q[0], cpu_in_debug_in};
			prst_sync_q <= {prst_sync_q[0], aux_port_reset_n_in};
			ded_sync_q  <= {ded_sync_q[0], ded_serial_debug_data_in};
			dbg_prev_q  <= dbg_sync_q[1];
		end
	end

	logic dbg_now;
	logic port_in_reset;
	assign dbg_now       = dbg_sync_q[1];
	assign port_in_reset = !prst_sync_q[1];

	// ----------------------------------------
	// path selection
	// ----------------------------------------
	logic aux_path_q;

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			aux_path_q <= PATH_DEDICATED;
		else if (port_in_reset && dev_ctrl_wr_in)
			aux_path_q <= dev_ctrl_aux_sel_in;
	end

	assign aux_path_out = aux_path_q;

	assign cpu_debug_enable_out = aux_path_q;
	assign cpu_debug_force_out  = aux_path_q && !port_in_reset && !dbg_now;

	// ----------------------------------------
	// serial engine
	// ----------------------------------------
	cdap_state_t            state_q;
	logic [WORD_W-1:0]      shreg_q;
	logic [CNT_W-1:0]       bit_cnt_q;
	logic                   out_pend_q;
	logic [5:0]             out_type_q;
	logic [WORD_W-1:0]      out_data_q;
	logic                   st_pend_q;
	logic                   st_val_q;
	logic                   err_pend_q;
	logic                   accept;
	logic                   known;
	logic                   active;
	logic                   send;

	assign active  = aux_path_q && !port_in_reset;
	assign known   = (msg_in_type_in == MTC_SDI_DATA);
	assign msg_in_ready_out = active && (state_q == CDAP_IDLE) && !err_pend_q;
	assign accept  = msg_in_valid_in && msg_in_ready_out;

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_q   <= CDAP_IDLE;
			shreg_q   <= '0;
			bit_cnt_q <= '0;
		end
		else
		begin
			case (state_q)
				CDAP_IDLE:
				begin
					if (accept && known)
					begin
						shreg_q   <= msg_in_data_in;
						bit_cnt_q <= CNT_W'(WORD_W);
						state_q   <= CDAP_SHIFT;
					end
				end
				CDAP_SHIFT:
				begin
					shreg_q   <= {shreg_q[WORD_W-2:0], serial_debug_data_in};
					bit_cnt_q <= bit_cnt_q - CNT_W'(1);
					if (bit_cnt_q == CNT_W'(1))
						state_q <= CDAP_ANSWER;
				end
				CDAP_ANSWER:
				begin
					if ((!out_pend_q || send) && !st_pend_q && !err_pend_q)
						state_q <= CDAP_IDLE;
				end
				default:
					state_q <= CDAP_IDLE;
			endcase
		end
	end

	assign serial_debug_clk_en_out = (state_q == CDAP_SHIFT);
	assign serial_debug_data_out   = aux_path_q ? shreg_q[WORD_W-1] : ded_sync_q[1];
	assign ded_serial_debug_data_out = aux_path_q ? 1'b0 : serial_debug_data_in;

	// ----------------------------------------
	// pending outgoing messages
	// ----------------------------------------
	assign send = out_pend_q && msg_out_ready_in;

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			st_pend_q  <= 1'b0;
			st_val_q   <= STATUS_EXITED;
			err_pend_q <= 1'b0;
		end
		else
		begin
			if (active && (dbg_now != dbg_prev_q))
			begin
				st_pend_q <= 1'b1;
				st_val_q  <= dbg_now ? STATUS_ENTERED : STATUS_EXITED;
			end
			else if ((!out_pend_q || send) && st_pend_q)
				st_pend_q <= 1'b0;
			if (accept && !known)
				err_pend_q <= 1'b1;
			else if ((!out_pend_q || send) && !st_pend_q && err_pend_q)
				err_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			out_pend_q <= 1'b0;
			out_type_q <= 6'h00;
			out_data_q <= '0;
		end
		else if (!out_pend_q || send)
		begin
			out_pend_q <= 1'b0;
			if (st_pend_q)
			begin
				out_pend_q <= 1'b1;
				out_type_q <= MTC_DEBUG_STATUS;
				out_data_q <= {{(WORD_W-1){1'b0}}, st_val_q};
			end
			else if (err_pend_q)
			begin
				out_pend_q <= 1'b1;
				out_type_q <= MTC_ERROR;
				out_data_q <= {{(WORD_W-8){1'b0}}, ERR_INVALID_TYPE};
			end
			else if (state_q == CDAP_ANSWER)
			begin
				out_pend_q <= 1'b1;
				out_type_q <= MTC_SDO_DATA;
				out_data_q <= shreg_q;
			end
		end
	end

	assign msg_out_valid_out = out_pend_q;
	assign msg_out_type_out  = out_type_q;
	assign msg_out_data_out  = out_data_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_shift_run;
		(state_q == CDAP_SHIFT) [*8];
	endsequence

	property p_sdi_shift;
		@(posedge clk_in) disable iff (!arst_n_in)
		accept && known |=> s_shift_run;
	endproperty
	a_sdi_shift: assert property (p_sdi_shift)
		else $error("shift did not start");

	property p_single_outstanding;
		@(posedge clk_in) disable iff (!arst_n_in)
		(state_q != CDAP_IDLE) |-> !msg_in_ready_out;
	endproperty
	a_single_outstanding: assert property (p_single_outstanding)
		else $error("input ready while busy");

	property p_entry_status;
		@(posedge clk_in) disable iff (!arst_n_in)
		active && $rose(dbg_now) ##1 !out_pend_q |=> out_pend_q
			&& out_type_q == MTC_DEBUG_STATUS && out_data_q[0] == STATUS_ENTERED;
	endproperty
	a_entry_status: assert property (p_entry_status)
		else $error("no entry status");

	property p_exit_status;
		@(posedge clk_in) disable iff (!arst_n_in)
		active && $fell(dbg_now) ##1 !out_pend_q |=> out_pend_q
			&& out_type_q == MTC_DEBUG_STATUS && out_data_q[0] == STATUS_EXITED;
	endproperty
	a_exit_status: assert property (p_exit_status)
		else $error("no exit status");

	property p_error_msg;
		@(posedge clk_in) disable iff (!arst_n_in)
		accept && !known |-> ##[1:4] out_pend_q && out_type_q == MTC_ERROR;
	endproperty
	a_error_msg: assert property (p_error_msg)
		else $error("no error message");

	property p_path_hold;
		@(posedge clk_in) disable iff (!arst_n_in)
		!port_in_reset |=> $stable(aux_path_q);
	endproperty
	a_path_hold: assert property (p_path_hold)
		else $error("path changed outside reset");

	property p_one_path;
		@(posedge clk_in) disable iff (!arst_n_in)
		!aux_path_q |-> !msg_in_ready_out && !cpu_debug_force_out;
	endproperty
	a_one_path: assert property (p_one_path)
		else $error("aux path active while not selected");

	property p_rate;
		@(posedge clk_in) disable iff (!arst_n_in)
		$rose(state_q == CDAP_SHIFT) |-> serial_debug_clk_en_out [*8];
	endproperty
	a_rate: assert property (p_rate)
		else $error("shift not at system rate");

endmodule : cdap_debug_access

// File: cdap_tool_model.sv
// development tool model on the aux message port
`timescale 1ns/1ps
module cdap_tool_model
(
	input  wire logic clk_in,
	input  wire logic slow_in,
	output logic      msg_out_ready_out
);
	logic [1:0] cnt_q;
	initial cnt_q = 2'h0;
	initial msg_out_ready_out = 1'b0;
	// ----------------------------------------
	// accept output messages, prompt or slow
	// ----------------------------------------
	// messages only
	always @(posedge clk_in)
	begin
		#1;
		cnt_q = cnt_q + 2'h1;
		msg_out_ready_out = !slow_in || (cnt_q == 2'h3);
	end
endmodule : cdap_tool_model

// File: cdap_debug_access_tb.sv
// self-checking bench for cdap_debug_access
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; \
	if ((a) !== (b)) begin mismatches++; \
	$display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module cdap_debug_access_tb
	import cdap_pkg::*;
;
	logic clk_in = 0, arst_n_in = 0, aux_port_reset_n_in = 0, dev_ctrl_wr_in = 0;
	logic dev_ctrl_aux_sel_in = 0, msg_in_valid_in = 0, msg_in_ready_out, msg_out_valid_out;
	logic [5:0] msg_in_type_in = 6'h00, msg_out_type_out;
	logic [WORD_W-1:0] msg_in_data_in = 35'h0, msg_out_data_out, cpu_sr = 35'h1_2345_6789;
	logic [WORD_W-1:0] prev, p;
	logic msg_out_ready_in, cpu_in_debug_in = 0, cpu_debug_enable_out, cpu_debug_force_out;
	logic ded_serial_debug_data_in = 0, ded_serial_debug_data_out, serial_debug_data_out;
	logic serial_debug_data_in, serial_debug_clk_en_out, aux_path_out, slow = 0;
	logic [15:0] rnd = 16'hEE5F;
	logic [40:0] exp_q[$], exp_v;
	int mismatches = 0, tests_run = 0, cycles = 0, shift_cnt = 0;
	always #4 clk_in = ~clk_in;
	assign serial_debug_data_in = cpu_sr[34];
	cdap_debug_access uut (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.aux_port_reset_n_in(aux_port_reset_n_in), .dev_ctrl_wr_in(dev_ctrl_wr_in),
		.dev_ctrl_aux_sel_in(dev_ctrl_aux_sel_in), .msg_in_valid_in(msg_in_valid_in),
		.msg_in_type_in(msg_in_type_in), .msg_in_data_in(msg_in_data_in),
		.msg_in_ready_out(msg_in_ready_out), .msg_out_valid_out(msg_out_valid_out),
		.msg_out_type_out(msg_out_type_out), .msg_out_data_out(msg_out_data_out),
		.msg_out_ready_in(msg_out_ready_in), .cpu_in_debug_in(cpu_in_debug_in),
		.cpu_debug_enable_out(cpu_debug_enable_out), .cpu_debug_force_out(cpu_debug_force_out),
		.ded_serial_debug_data_in(ded_serial_debug_data_in),
		.ded_serial_debug_data_out(ded_serial_debug_data_out),
		.serial_debug_data_out(serial_debug_data_out), .serial_debug_data_in(serial_debug_data_in),
		.serial_debug_clk_en_out(serial_debug_clk_en_out), .aux_path_out(aux_path_out));
	cdap_tool_model tool (.clk_in(clk_in), .slow_in(slow), .msg_out_ready_out(msg_out_ready_in));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	task tally_and_finish();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task send(input logic [5:0] t, input logic [WORD_W-1:0] d);
		int n;
		n = 0;
		msg_in_valid_in = 1'b1;
		msg_in_type_in = t;
		msg_in_data_in = d;
		while (msg_in_ready_out !== 1'b1 && n < 300)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		@(posedge clk_in);
		#1;
		msg_in_valid_in = 1'b0;
	endtask : send
	task drain();
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 300)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		if (n == 300)
			mismatches++;
		repeat (3) @(posedge clk_in);
		#1;
	endtask : drain
	// ----------------------------------------
	// cpu shift path model and output monitor
	// ----------------------------------------
	always @(posedge clk_in)
	begin
		cycles++;
		if (serial_debug_clk_en_out === 1'b1)
		begin
			cpu_sr <= {cpu_sr[33:0], serial_debug_data_out};
			shift_cnt <= shift_cnt + 1;
		end
		if (cycles == 20000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end
	always @(negedge clk_in)
		if (msg_out_valid_out === 1'b1 && msg_out_ready_in === 1'b1)
		begin
			`CHK(exp_q.size() > 0, 1'b1)
			exp_v = exp_q.pop_front();
			`CHK({msg_out_type_out, msg_out_data_out}, exp_v)
		end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clk_in);
		#1;
		arst_n_in = 1'b1;
		ded_serial_debug_data_in = 1'b1;
		repeat (3) @(posedge clk_in);
		#1;
		`CHK({aux_path_out, cpu_debug_enable_out, cpu_debug_force_out}, 3'h0)
		`CHK(serial_debug_data_out, 1'b1)
		`CHK(ded_serial_debug_data_out, cpu_sr[34])
		dev_ctrl_aux_sel_in = 1'b1;
		dev_ctrl_wr_in = 1'b1;
		@(posedge clk_in);
		#1;
		dev_ctrl_wr_in = 1'b0;
		`CHK(msg_in_ready_out, 1'b0)
		aux_port_reset_n_in = 1'b1;
		repeat (4) @(posedge clk_in);
		#1;
		`CHK({aux_path_out, cpu_debug_enable_out, cpu_debug_force_out}, 3'h7)
		`CHK(ded_serial_debug_data_out, 1'b0)
		exp_q.push_back({MTC_DEBUG_STATUS, 35'(STATUS_ENTERED)});
		cpu_in_debug_in = 1'b1;
		drain();
		`CHK(cpu_debug_force_out, 1'b0)
		prev = cpu_sr;
		for (int i = 0; i < 4; i++)
		begin
			rnd = lfsr_next(rnd);
			p[34:16] = {rnd[2:0], rnd};
			rnd = lfsr_next(rnd);
			p[15:0] = rnd;
			ded_serial_debug_data_in = rnd[5];
			slow = i[0];
			shift_cnt = 0;
			exp_q.push_back({MTC_SDO_DATA, prev});
			send(MTC_SDI_DATA, p);
			drain();
			`CHK(shift_cnt, 35)
			`CHK(cpu_sr, p)
			prev = p;
		end
		exp_q.push_back({MTC_ERROR, 35'(ERR_INVALID_TYPE)});
		send(6'h15, {rnd[2:0], rnd, rnd});
		drain();
		exp_q.push_back({MTC_DEBUG_STATUS, 35'(STATUS_EXITED)});
		cpu_in_debug_in = 1'b0;
		drain();
		`CHK(cpu_debug_force_out, 1'b1)
		dev_ctrl_aux_sel_in = 1'b0;
		dev_ctrl_wr_in = 1'b1;
		@(posedge clk_in);
		#1;
		dev_ctrl_wr_in = 1'b0;
		@(posedge clk_in);
		#1;
		`CHK(aux_path_out, 1'b1)
		tally_and_finish();
	end
endmodule : cdap_debug_access_tb
